// ### hw/lts_pkg.sv
// Package: register map, encodings and timing for the trigger/system block
package lts_pkg;

	// ********************************************************************
	// Register byte offsets
	// ********************************************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_CMD       = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_ERR       = 8'h0c;
	localparam logic [7:0] OFS_VERSION   = 8'h10;
	localparam logic [7:0] OFS_MEAS      = 8'h14;
	localparam logic [7:0] OFS_IMM_VAL   = 8'h18;
	localparam logic [7:0] OFS_TRIG_VAL  = 8'h1c;
	localparam logic [7:0] OFS_PROG_SEL  = 8'h20;
	localparam logic [7:0] OFS_PROG_CFG  = 8'h24;
	localparam logic [7:0] OFS_MEMO0     = 8'h28;
	localparam logic [7:0] OFS_MEMO3     = 8'h34;
	localparam logic [7:0] OFS_ENERGY    = 8'h38;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int CTRL_CONT_BIT   = 0;
	localparam int CTRL_KLOCK_BIT  = 1;
	localparam int CTRL_PAR_BIT    = 2;
	localparam int CMD_ARM_BIT     = 0;
	localparam int CMD_ABORT_BIT   = 1;
	localparam int CMD_TRIG_BIT    = 2;
	localparam int CMD_LOCAL_BIT   = 3;
	localparam int CMD_REMOTE_BIT  = 4;
	localparam int CMD_RWL_BIT     = 5;
	localparam int CMD_ECLR_BIT    = 6;
	localparam int CMD_MEAS_BIT    = 7;
	localparam int CMD_QSEL_LSB    = 8;
	localparam int CFG_MODE_LSB    = 0;
	localparam int CFG_ENDLOAD_BIT = 4;
	localparam int CFG_LOOP_LSB    = 16;

	// ********************************************************************
	// Reset values and limits
	// ********************************************************************
	localparam logic        CONT_RST       = 1'b0;
	localparam logic [3:0]  PROG_SEL_RST   = 4'h1;
	localparam logic [3:0]  PROG_MIN       = 4'h1;
	localparam logic [3:0]  PROG_MAX       = 4'ha;
	localparam int          PROG_COUNT     = 10;
	localparam int          MEMO_CHARS     = 15;
	localparam logic [13:0] LOOP_MIN       = 14'h0001;
	localparam logic [13:0] LOOP_MAX       = 14'h270f;
	localparam logic [13:0] LOOP_RST       = 14'h0001;
	localparam logic        ENDLOAD_RST    = 1'b0;
	localparam int          ERRQ_DEPTH     = 255;
	localparam logic [7:0]  ERRQ_LAST      = 8'hfe;
	localparam logic [7:0]  ERRQ_FULL      = 8'hff;
	localparam logic [31:0] VERSION_WORD   = 32'h07cf_0000;

	// ********************************************************************
	// Error codes (two's complement, 16 bits)
	// ********************************************************************
	localparam logic [15:0] ERR_CMD        = 16'hff9c; // -100
	localparam logic [15:0] ERR_TRIG_IGN   = 16'hff2d; // -211
	localparam logic [15:0] ERR_DATA_RANGE = 16'hff22; // -222

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int CLK_PERIOD_NS   = 5;
	localparam int CHANGE_TIME_NS  = 50;
	localparam int CHANGE_CYCLES   =
		(CHANGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************************************************
	// Types
	// ********************************************************************
	typedef enum logic [1:0] {
		TRG_IDLE     = 2'b00,
		TRG_ARMED    = 2'b01,
		TRG_CHANGING = 2'b11
	} lts_trig_e;

	typedef enum logic [1:0] {
		RMT_LOCAL   = 2'b00,
		RMT_REMOTE  = 2'b01,
		RMT_LOCKOUT = 2'b11
	} lts_remote_e;

	typedef enum logic [1:0] {
		MODE_CC = 2'b00,
		MODE_CV = 2'b01,
		MODE_CP = 2'b10,
		MODE_CR = 2'b11
	} lts_mode_e;

	typedef enum logic [2:0] {
		Q_CURRENT = 3'h0,
		Q_VOLTAGE = 3'h1,
		Q_POWER   = 3'h2,
		Q_REGEN   = 3'h3,
		Q_ENERGY  = 3'h4,
		Q_ETIME   = 3'h5
	} lts_quant_e;

	typedef struct packed {
		lts_mode_e   mode;
		logic        end_load;
		logic        spare;
		logic [13:0] loop_count;
	} lts_prog_s;

	localparam lts_prog_s PROG_RST =
		'{MODE_CC, ENDLOAD_RST, 1'b0, LOOP_RST};

endpackage

// ### hw/lts_core.sv
// Trigger, measurement, error queue, remote mode and program store
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Continuous on: trigger applies change, then returns to waiting for trigger.
// - Continuous off: trigger applies change, then goes idle as after abort.
// - Continuous setting: 1 on, 0 off, default off, read back as integer.
// - Trigger machine starts idle after reset, same as after abort.
// - Abort ends any armed or pending trigger and returns to idle.
// - Armed and waiting, a software trigger starts the pending change.
// - Trigger when not waiting or while changing is rejected, queues -211.
// - Measure-style query behaves exactly like read-style query.
// - Read-style query starts a fresh measurement before returning data.
// - Six quantities each return one value: A, V, W, W, Wh, s.
// - Error queue holds 255 entries; each query returns and removes oldest.
// - Panel lock: 1 locks front panel, 0 releases; read back as integer.
// - Go-local enters local mode; on the parallel bus queues -100 instead.
// - Go-remote enters remote with all keys locked except return-to-local.
// - Remote lockout locks every key; only go-local leaves it.
// - Version query returns 1999.0.
// - Energy clear resets accumulated regenerated energy to zero.
// - Program select takes 1 to 10, default 1; config targets it.
// - Each program stores a memo of at most 15 characters.
// - Each program stores loop count 1 to 9999; 9999 means forever.
// - Each program stores end load state: 1 stays on, 0 turns off.
// - Arm moves to waiting-for-trigger; bus or common trigger serves it. Here only the bus trigger command serves it; there is no common trigger input.
// - Abort or direct setting change discards pending trigger values.
module lts_core (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Measurement unit
	input  wire logic        meas_valid,
	input  wire logic [31:0] meas_data,
	input  wire logic        energy_inc_valid,
	input  wire logic [31:0] energy_inc,
	output logic             meas_start,
	output logic [2:0]       meas_sel,
	// Setting output towards load control
	output logic [31:0]      setting_value,
	output logic             setting_apply,
	// Front panel
	output logic             panel_keys_locked,
	output logic             local_key_locked,
	output logic             remote_mode,
	// Selected program
	output logic [17:0]      prog_cfg_out
);

	// ********************************************************************
	// State
	// ********************************************************************
	lts_pkg::lts_trig_e   trig_reg;
	lts_pkg::lts_remote_e remote_reg;
	lts_pkg::lts_prog_s   prog_reg [0:lts_pkg::PROG_COUNT-1];
	logic [7:0]           memo_reg [0:lts_pkg::PROG_COUNT-1][0:15];
	logic [15:0]          errq_reg [0:lts_pkg::ERRQ_DEPTH-1];
	logic [7:0]           err_wr_reg;
	logic [7:0]           err_rd_reg;
	logic [7:0]           err_cnt_reg;
	logic                 cont_reg;
	logic                 klock_reg;
	logic                 par_link_reg;
	logic [31:0]          imm_reg;
	logic [31:0]          trig_val_reg;
	logic [7:0]           chg_cnt_reg;
	logic [3:0]           prog_sel_reg;
	logic                 meas_busy_reg;
	logic [2:0]           meas_sel_reg;
	logic [31:0]          meas_reg;
	logic [31:0]          energy_reg;
	logic [31:0]          prdata_reg;
	logic                 pready_reg;
	logic                 pslverr_reg;

	// ********************************************************************
	// Bus decode
	// ********************************************************************
	logic        acc;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [3:0]  pidx;
	logic [31:0] rdata_next;
	logic        cmd_arm;
	logic        cmd_abort;
	logic        cmd_trig;
	logic        cmd_local;
	logic        cmd_remote;
	logic        cmd_rwl;
	logic        cmd_eclr;
	logic        cmd_meas;
	logic        sel_ok;
	logic        loop_ok;
	logic        err_push;
	logic [15:0] err_code;
	logic        err_pop;
	logic        chg_done;

	// Access edge: request held and our ready already up
	assign acc  = psel & penable & pready_reg;
	assign wr   = acc & pwrite;
	assign rd   = acc & ~pwrite;
	assign pidx = prog_sel_reg - lts_pkg::PROG_MIN;

	// Command bits, effective only at the access edge
	assign cmd_arm    = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_ARM_BIT];
	assign cmd_abort  = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_ABORT_BIT];
	assign cmd_trig   = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_TRIG_BIT];
	assign cmd_local  = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_LOCAL_BIT];
	assign cmd_remote = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_REMOTE_BIT];
	assign cmd_rwl    = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_RWL_BIT];
	assign cmd_eclr   = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_ECLR_BIT];
	assign cmd_meas   = wr && paddr == lts_pkg::OFS_CMD &&
		pwdata[lts_pkg::CMD_MEAS_BIT];

	// Range checks on program writes
	assign sel_ok  = pwdata[3:0] >= lts_pkg::PROG_MIN &&
		pwdata[3:0] <= lts_pkg::PROG_MAX && pwdata[31:4] == 28'h0000000;
	assign loop_ok = pwdata[29:16] >= lts_pkg::LOOP_MIN &&
		pwdata[29:16] <= lts_pkg::LOOP_MAX;

	assign chg_done = trig_reg == lts_pkg::TRG_CHANGING &&
		chg_cnt_reg == 8'(lts_pkg::CHANGE_CYCLES - 1);

	// Error sources; one command word yields at most one error
	always_comb begin
		err_push = 1'b0;
		err_code = lts_pkg::ERR_CMD;
		if (cmd_trig && trig_reg != lts_pkg::TRG_ARMED) begin
			err_push = 1'b1;
			err_code = lts_pkg::ERR_TRIG_IGN;
		end else if ((cmd_local | cmd_remote | cmd_rwl) && par_link_reg) begin
			err_push = 1'b1;
			err_code = lts_pkg::ERR_CMD;
		end else if (wr && paddr == lts_pkg::OFS_PROG_SEL && !sel_ok) begin
			err_push = 1'b1;
			err_code = lts_pkg::ERR_DATA_RANGE;
		end else if (wr && paddr == lts_pkg::OFS_PROG_CFG && !loop_ok) begin
			err_push = 1'b1;
			err_code = lts_pkg::ERR_DATA_RANGE;
		end
	end

	assign err_pop = rd && paddr == lts_pkg::OFS_ERR && err_cnt_reg != 8'h00;

	// Read mux, sampled in the setup cycle
	always_comb begin
		rdata_next = 32'h00000000;
		mapped     = 1'b1;
		case (paddr)
			lts_pkg::OFS_CTRL: begin
				rdata_next[lts_pkg::CTRL_CONT_BIT]  = cont_reg;
				rdata_next[lts_pkg::CTRL_KLOCK_BIT] = klock_reg;
				rdata_next[lts_pkg::CTRL_PAR_BIT]   = par_link_reg;
			end
			lts_pkg::OFS_CMD: rdata_next = 32'h00000000;
			lts_pkg::OFS_STATUS: begin
				rdata_next[1:0]  = trig_reg;
				rdata_next[3:2]  = remote_reg;
				rdata_next[4]    = meas_busy_reg;
				rdata_next[15:8] = err_cnt_reg;
			end
			lts_pkg::OFS_ERR: begin
				if (err_cnt_reg != 8'h00) begin
					rdata_next = {{16{errq_reg[err_rd_reg][15]}},
						errq_reg[err_rd_reg]};
				end
			end
			lts_pkg::OFS_VERSION:  rdata_next = lts_pkg::VERSION_WORD;
			lts_pkg::OFS_MEAS:     rdata_next = meas_reg;
			lts_pkg::OFS_IMM_VAL:  rdata_next = imm_reg;
			lts_pkg::OFS_TRIG_VAL: rdata_next = trig_val_reg;
			lts_pkg::OFS_PROG_SEL: rdata_next[3:0] = prog_sel_reg;
			lts_pkg::OFS_PROG_CFG: begin
				rdata_next[lts_pkg::CFG_MODE_LSB +: 2] = prog_reg[pidx].mode;
				rdata_next[lts_pkg::CFG_ENDLOAD_BIT] =
					prog_reg[pidx].end_load;
				rdata_next[lts_pkg::CFG_LOOP_LSB +: 14] =
					prog_reg[pidx].loop_count;
			end
			lts_pkg::OFS_ENERGY:   rdata_next = energy_reg;
			default: begin
				if (paddr >= lts_pkg::OFS_MEMO0 &&
					paddr <= lts_pkg::OFS_MEMO3 && paddr[1:0] == 2'b00) begin
					for (int b = 0; b < 4; b++) begin
						rdata_next[8*b +: 8] = memo_reg[pidx]
							[{paddr[3:2] - 2'b10, 2'(b)}];
					end
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// ********************************************************************
	// APB answer: no wait state, and every answer still comes from a flop
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
		end else begin
			pready_reg  <= psel & ~penable;
			pslverr_reg <= psel & ~penable & ~mapped;
			if (psel & ~penable & ~pwrite) begin
				prdata_reg <= rdata_next;
			end
		end
	end

	// ********************************************************************
	// Control register
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cont_reg     <= lts_pkg::CONT_RST;
			klock_reg    <= 1'b0;
			par_link_reg <= 1'b0;
		end else if (wr && paddr == lts_pkg::OFS_CTRL) begin
			cont_reg     <= pwdata[lts_pkg::CTRL_CONT_BIT];
			klock_reg    <= pwdata[lts_pkg::CTRL_KLOCK_BIT];
			par_link_reg <= pwdata[lts_pkg::CTRL_PAR_BIT];
		end
	end

	// ********************************************************************
	// Trigger state machine
	// ********************************************************************
	// Abort has priority over arm and trigger in the same word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_reg    <= lts_pkg::TRG_IDLE;
			chg_cnt_reg <= 8'h00;
		end else begin
			case (trig_reg)
				lts_pkg::TRG_IDLE: begin
					if (cmd_arm && !cmd_abort) begin
						trig_reg <= lts_pkg::TRG_ARMED;
					end
				end
				lts_pkg::TRG_ARMED: begin
					if (cmd_abort) begin
						trig_reg <= lts_pkg::TRG_IDLE;
					end else if (cmd_trig) begin
						trig_reg    <= lts_pkg::TRG_CHANGING;
						chg_cnt_reg <= 8'h00;
					end
				end
				lts_pkg::TRG_CHANGING: begin
					chg_cnt_reg <= chg_cnt_reg + 8'h01;
					if (cmd_abort) begin
						trig_reg <= lts_pkg::TRG_IDLE;
					end else if (chg_done) begin
						trig_reg <= cont_reg ? lts_pkg::TRG_ARMED
							: lts_pkg::TRG_IDLE;
					end
				end
				default: trig_reg <= lts_pkg::TRG_IDLE;
			endcase
		end
	end

	// Immediate and pending setting values
	// Writing either value while a change runs is allowed; last write wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imm_reg       <= 32'h00000000;
			trig_val_reg  <= 32'h00000000;
			setting_apply <= 1'b0;
		end else begin
			setting_apply <= cmd_trig && !cmd_abort &&
				trig_reg == lts_pkg::TRG_ARMED;
			if (wr && paddr == lts_pkg::OFS_IMM_VAL) begin
				imm_reg      <= pwdata;
				trig_val_reg <= pwdata;
			end else if (cmd_abort) begin
				trig_val_reg <= imm_reg;
			end else if (cmd_trig && trig_reg == lts_pkg::TRG_ARMED) begin
				imm_reg <= trig_val_reg;
			end else if (wr && paddr == lts_pkg::OFS_TRIG_VAL) begin
				trig_val_reg <= pwdata;
			end
		end
	end

	assign setting_value = imm_reg;

	// ********************************************************************
	// Measurement and regenerated energy
	// ********************************************************************
	// Both query styles use the same command bit, so they cannot differ
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_busy_reg <= 1'b0;
			meas_sel_reg  <= 3'h0;
			meas_reg      <= 32'h00000000;
			meas_start    <= 1'b0;
		end else begin
			meas_start <= cmd_meas && !meas_busy_reg;
			if (cmd_meas && !meas_busy_reg) begin
				meas_busy_reg <= 1'b1;
				meas_sel_reg  <= pwdata[lts_pkg::CMD_QSEL_LSB +: 3];
			end else if (meas_busy_reg && meas_valid) begin
				meas_busy_reg <= 1'b0;
				meas_reg <= meas_sel_reg == lts_pkg::Q_ENERGY ?
					energy_reg : meas_data;
			end
		end
	end

	assign meas_sel = meas_sel_reg;

	// Clear wins over a coinciding increment; that sample is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_reg <= 32'h00000000;
		end else if (cmd_eclr) begin
			energy_reg <= 32'h00000000;
		end else if (energy_inc_valid) begin
			energy_reg <= energy_reg + energy_inc;
		end
	end

	// ********************************************************************
	// Error queue
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_wr_reg  <= 8'h00;
			err_rd_reg  <= 8'h00;
			err_cnt_reg <= 8'h00;
		end else begin
			if (err_push && err_cnt_reg != lts_pkg::ERRQ_FULL) begin
				errq_reg[err_wr_reg] <= err_code;
				err_wr_reg <= err_wr_reg == lts_pkg::ERRQ_LAST ? 8'h00
					: err_wr_reg + 8'h01;
			end
			if (err_pop) begin
				err_rd_reg <= err_rd_reg == lts_pkg::ERRQ_LAST ? 8'h00
					: err_rd_reg + 8'h01;
			end
			err_cnt_reg <= err_cnt_reg
				+ 8'(err_push && err_cnt_reg != lts_pkg::ERRQ_FULL)
				- 8'(err_pop);
		end
	end

	// ********************************************************************
	// Remote / local mode and panel locks
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_reg <= lts_pkg::RMT_LOCAL;
		end else if (!par_link_reg) begin
			if (cmd_local) begin
				remote_reg <= lts_pkg::RMT_LOCAL;
			end else if (cmd_rwl) begin
				remote_reg <= lts_pkg::RMT_LOCKOUT;
			end else if (cmd_remote && remote_reg != lts_pkg::RMT_LOCKOUT) begin
				remote_reg <= lts_pkg::RMT_REMOTE;
			end
		end
	end

	// Registered so the panel sees glitch-free lock levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_keys_locked <= 1'b0;
			local_key_locked  <= 1'b0;
			remote_mode       <= 1'b0;
		end else begin
			panel_keys_locked <= klock_reg |
				(remote_reg != lts_pkg::RMT_LOCAL);
			local_key_locked  <= klock_reg |
				(remote_reg == lts_pkg::RMT_LOCKOUT);
			remote_mode       <= remote_reg != lts_pkg::RMT_LOCAL;
		end
	end

	// ********************************************************************
	// Program store
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_sel_reg <= lts_pkg::PROG_SEL_RST;
		end else if (wr && paddr == lts_pkg::OFS_PROG_SEL && sel_ok) begin
			prog_sel_reg <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < lts_pkg::PROG_COUNT; p++) begin
				prog_reg[p] <= lts_pkg::PROG_RST;
			end
		end else if (wr && paddr == lts_pkg::OFS_PROG_CFG && loop_ok) begin
			prog_reg[pidx].mode <= lts_pkg::lts_mode_e'(
				pwdata[lts_pkg::CFG_MODE_LSB +: 2]);
			prog_reg[pidx].end_load <= pwdata[lts_pkg::CFG_ENDLOAD_BIT];
			prog_reg[pidx].loop_count <=
				pwdata[lts_pkg::CFG_LOOP_LSB +: 14];
		end
	end

	// Memo bytes, byte-lane writes; the sixteenth byte is never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int p = 0; p < lts_pkg::PROG_COUNT; p++) begin
				for (int c = 0; c < 16; c++) begin
					memo_reg[p][c] <= 8'h00;
				end
			end
		end else if (wr && paddr >= lts_pkg::OFS_MEMO0 &&
			paddr <= lts_pkg::OFS_MEMO3 && paddr[1:0] == 2'b00) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b] && {paddr[3:2] - 2'b10, 2'(b)} <
					4'(lts_pkg::MEMO_CHARS)) begin
					memo_reg[pidx][{paddr[3:2] - 2'b10, 2'(b)}] <=
						pwdata[8*b +: 8];
				end
			end
		end
	end

	// Selected program shown to the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_cfg_out <= lts_pkg::PROG_RST;
		end else begin
			prog_cfg_out <= prog_reg[pidx];
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

endmodule

// ### test/lts_meas_model.sv
// Measurement unit model answering start pulses
`timescale 1ns/1ps
module lts_meas_model #(
	parameter int DELAY = 3
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Start request and answer
	input  wire logic        meas_start,
	input  wire logic [2:0]  meas_sel,
	output logic             meas_valid,
	output logic [31:0]      meas_data
);
	int cnt;
	// Data toggles outside the pulse so stale bits never pass as fresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			meas_valid <= 1'b0;
			meas_data <= 32'h0;
		end else begin
			meas_valid <= cnt == 1;
			meas_data <= (cnt == 1) ? {29'h20, meas_sel} : ~meas_data;
			if (meas_start)
				cnt <= DELAY;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// ### test/lts_monitor.sv
// Port checker for the trigger and system core
`timescale 1ns/1ps
module lts_monitor (
	// Clock, reset and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// Watched outputs
	input wire logic        meas_start,
	input wire logic [2:0]  meas_sel,
	input wire logic        setting_apply,
	input wire logic        panel_keys_locked,
	input wire logic        local_key_locked,
	input wire logic        remote_mode,
	input wire logic [17:0] prog_cfg_out
);
	// Completed write, and one aimed at the command word
	wire logic wr = psel && penable && pwrite;
	wire logic cmd = wr && paddr == lts_pkg::OFS_CMD;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ******
	// Properties
	// ******
	property p_meas; meas_start |-> $past(cmd && pwdata[7]); endproperty
	property p_sel; $changed(meas_sel) |-> meas_start; endproperty
	property p_apply; setting_apply |-> $past(cmd && pwdata[2]); endproperty
	property p_gap; setting_apply |=> !setting_apply [*8]; endproperty
	property p_rem; remote_mode |-> panel_keys_locked; endproperty
	property p_rwl; local_key_locked |-> panel_keys_locked; endproperty
	property p_loop;
		prog_cfg_out[13:0] >= 14'h1 && prog_cfg_out[13:0] <= 14'h270f;
	endproperty
	property p_cfg; $changed(prog_cfg_out) |-> $past(wr, 2); endproperty
	a_meas: assert property (p_meas)
		else $error("measure start without command");
	a_sel: assert property (p_sel)
		else $error("quantity moved without start");
	a_apply: assert property (p_apply)
		else $error("apply without trigger");
	a_gap: assert property (p_gap)
		else $error("apply during change");
	a_rem: assert property (p_rem)
		else $error("remote with keys free");
	a_rwl: assert property (p_rwl)
		else $error("local key locked alone");
	a_loop: assert property (p_loop)
		else $error("loop count out of range");
	a_cfg: assert property (p_cfg)
		else $error("program config moved alone");
	// Main scenarios reached
	c_apply: cover property (setting_apply);
	c_meas: cover property (meas_start);
	c_rwl: cover property (local_key_locked && remote_mode);
endmodule
bind lts_core lts_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .meas_start, .meas_sel, .setting_apply,
	.panel_keys_locked, .local_key_locked, .remote_mode, .prog_cfg_out);

// ### test/tb_lts_core.sv
// Bus-level testbench for the trigger and system core
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	checked++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("MISMATCH %s exp %h got %h", n, e, g); \
	end \
end
module tb_lts_core;
	logic pclk, presetn, psel, penable, pwrite, meas_valid, e;
	logic energy_inc_valid, meas_start, setting_apply, pready, pslverr;
	logic panel_keys_locked, local_key_locked, remote_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, meas_data, energy_inc, setting_value, r;
	logic [3:0]  pstrb;
	logic [2:0]  meas_sel;
	logic [17:0] prog_cfg_out;
	int errors, checked;
	lts_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .meas_valid,
		.meas_data, .energy_inc_valid, .energy_inc, .meas_start,
		.meas_sel, .setting_value, .setting_apply, .panel_keys_locked,
		.local_key_locked, .remote_mode, .prog_cfg_out);
	lts_meas_model #(.DELAY(3)) model (.pclk, .presetn, .meas_start,
		.meas_sel, .meas_valid, .meas_data);
	// ******
	// Bus tasks
	// ******
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic cmd(input logic [31:0] d);
		apb(1'b1, lts_pkg::OFS_CMD, d);
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(n, x, r)
	endtask
	// Busy is polled, never a fixed wait, so slow answers still pass
	task automatic meas(input logic [2:0] q);
		cmd({21'h0, q, 8'h80});
		r = 32'h10;
		for (int i = 0; i < 20 && r[4]; i++) apb(1'b0, lts_pkg::OFS_STATUS, 0);
		apb(1'b0, lts_pkg::OFS_MEAS, 32'h0);
	endtask
	task automatic test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#100000;
		errors++;
		test_done;
	end
	// ******
	// Scenarios
	// ******
	initial begin
		{presetn, psel, penable, pwrite, energy_inc_valid} = 5'h0;
		{paddr, pwdata, energy_inc, pstrb} = 76'hf;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc("ctrl", lts_pkg::OFS_CTRL, 32'h0);
		rdc("status", lts_pkg::OFS_STATUS, 32'h0);
		rdc("version", lts_pkg::OFS_VERSION, lts_pkg::VERSION_WORD);
		rdc("sel", lts_pkg::OFS_PROG_SEL, 32'h1);
		rdc("cfg", lts_pkg::OFS_PROG_CFG, 32'h0001_0000);
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("slverr", 1'b1, e)
		repeat (256) cmd(32'h4);
		rdc("count", lts_pkg::OFS_STATUS, 32'hff00);
		rdc("err", lts_pkg::OFS_ERR, 32'hffff_ff2d);
		rdc("count", lts_pkg::OFS_STATUS, 32'hfe00);
		repeat (254) apb(1'b0, lts_pkg::OFS_ERR, 32'h0);
		rdc("err", lts_pkg::OFS_ERR, 32'h0);
		wr(lts_pkg::OFS_TRIG_VAL, 32'h78);
		cmd(32'h1);
		rdc("armed", lts_pkg::OFS_STATUS, 32'h1);
		cmd(32'h4);
		rdc("chg", lts_pkg::OFS_STATUS, 32'h3);
		repeat (12) @(posedge pclk);
		rdc("idle", lts_pkg::OFS_STATUS, 32'h0);
		`CHK("value", 32'h78, setting_value)
		wr(lts_pkg::OFS_CTRL, 32'h1);
		rdc("cont", lts_pkg::OFS_CTRL, 32'h1);
		wr(lts_pkg::OFS_TRIG_VAL, 32'h99);
		cmd(32'h1);
		cmd(32'h4);
		cmd(32'h4);
		rdc("err", lts_pkg::OFS_ERR, 32'hffff_ff2d);
		repeat (14) @(posedge pclk);
		rdc("rearm", lts_pkg::OFS_STATUS, 32'h1);
		`CHK("value", 32'h99, setting_value)
		wr(lts_pkg::OFS_IMM_VAL, 32'h10);
		wr(lts_pkg::OFS_TRIG_VAL, 32'h20);
		cmd(32'h2);
		rdc("abort", lts_pkg::OFS_STATUS, 32'h0);
		rdc("pend", lts_pkg::OFS_TRIG_VAL, 32'h10);
		for (int q = 0; q < 6; q++) if (q != 4) begin
			meas(q[2:0]);
			`CHK("meas", {29'h20, q[2:0]}, r)
			`CHK("sel", q[2:0], meas_sel)
		end
		energy_inc <= 32'h5;
		energy_inc_valid <= 1'b1;
		repeat (2) @(posedge pclk);
		energy_inc_valid <= 1'b0;
		meas(3'h4);
		`CHK("energy", 32'ha, r)
		cmd(32'h40);
		rdc("eclr", lts_pkg::OFS_ENERGY, 32'h0);
		cmd(32'h10);
		rdc("remote", lts_pkg::OFS_STATUS, 32'h4);
		`CHK("lkey", 1'b0, local_key_locked)
		`CHK("pkey", 1'b1, panel_keys_locked)
		cmd(32'h20);
		cmd(32'h10);
		rdc("rwl", lts_pkg::OFS_STATUS, 32'hc);
		`CHK("rmode", 1'b1, remote_mode)
		cmd(32'h8);
		rdc("local", lts_pkg::OFS_STATUS, 32'h0);
		wr(lts_pkg::OFS_CTRL, 32'h6);
		cmd(32'h8);
		rdc("err", lts_pkg::OFS_ERR, 32'hffff_ff9c);
		`CHK("klock", 1'b1, local_key_locked)
		wr(lts_pkg::OFS_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		`CHK("klock", 1'b0, panel_keys_locked)
		wr(lts_pkg::OFS_PROG_SEL, 32'hb);
		rdc("sel", lts_pkg::OFS_PROG_SEL, 32'h1);
		rdc("err", lts_pkg::OFS_ERR, 32'hffff_ff22);
		wr(lts_pkg::OFS_PROG_SEL, 32'h3);
		for (int m = 0; m < 4; m++) begin
			wr(lts_pkg::OFS_PROG_CFG, {30'h4000, m[1:0]});
			rdc("mode", lts_pkg::OFS_PROG_CFG, {30'h4000, m[1:0]});
		end
		wr(lts_pkg::OFS_PROG_CFG, 32'h270f_0012);
		wr(lts_pkg::OFS_PROG_CFG, 32'h0000_0000);
		rdc("cfg", lts_pkg::OFS_PROG_CFG, 32'h270f_0012);
		`CHK("pcfg", 18'h2a70f, prog_cfg_out)
		wr(lts_pkg::OFS_MEMO3, 32'hffff_ffff);
		rdc("memo", lts_pkg::OFS_MEMO3, 32'h00ff_ffff);
		wr(lts_pkg::OFS_PROG_SEL, 32'h1);
		rdc("cfg", lts_pkg::OFS_PROG_CFG, 32'h0001_0000);
		test_done;
	end
endmodule
